/* File: core/dac_ctrl.sv */
/*
 * Event routing, sync control, transmit muting and calibration registers.
 * Assumes event inputs and calibration results come from logic on clk_sys;
 * sync edge and transmit gate pins are asynchronous and are resynchronised.
 */
// Functional notes
// - Disabled events show live status; enabled events latch and pull their pin low.
// - Writing one to a latched status bit clears it; zero does nothing.
// - Route bit zero selects pin a, one selects pin b.
// - Link route register bits 4..0: jitter, not ready, lane, imag, real.
// - Per-converter route registers: bit 3 calibration done, bit 0 amp error.
// - Clocking route bits: 5 dll lost, 4 dll lock, 1 pll lost, 0 pll lock.
// - Summary bit reads OR of all four status registers.
// - Writing one to summary clears every latched status bit.
// - Pulse counting ignores programmed number of rising sync edges first.
// - Edge deviation beyond seven-bit window raises the jitter event.
// - Read-only rotation-complete flag, one after reset.
// - Monitor mode sets jitter flag when edge is outside window.
// - One-shot mode syncs once on the first edge after the skipped count, then returns to monitor.
// - Oscillator-reset bit resets all oscillators after rotation or digital reset.
// - Action bit 0 drops links and realigns serializer clocks on rotation.
// - Action bit 1 ramps datapath off and on with soft gain.
// - Mute select zeroes converter output while its gate pin is low.
// - Calibration status: bit 2 active, bit 1 failed, bit 0 complete.
// - Calibration control, status and full-scale fields are banked per converter by page.
// - Full-scale code is ten bits: two low, eight high.
// - Each set page bit selects one converter; both may be written.
module dac_ctrl #(
   parameter int SYNC_PERIOD = 64
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [11:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic [7:0]       rdata,
   input  wire logic [12:0] event_live,
   input  wire logic        digital_reset,
   input  wire logic        sync_edge_pin,
   input  wire logic        transmit_gate_pin_0,
   input  wire logic        transmit_gate_pin_1,
   input  wire logic [1:0]  calib_fail_in,
   output logic             event_pin_a_n,
   output logic             event_pin_b_n,
   output logic [1:0]       conv_mute,
   output logic             serdes_realign,
   output logic             soft_gain_ramp,
   output logic             oscillator_reset,
   output logic [9:0]       full_scale_code_0,
   output logic [9:0]       full_scale_code_1
);
   `include "dac_ctrl_defines.svh"

   // Reset full-scale code: upper eight bits beside the two low bits
   localparam logic [9:0] FSC_RST = {`RST_FSC_HI, 2'(`RST_FSC_LO & 8'h03)};

   initial begin
      if (SYNC_PERIOD < 2 || SYNC_PERIOD > 255) $error("SYNC_PERIOD out of range");
   end

   dac_ctrl_pkg::reg_req_t req;
   assign req = '{we: wr_stb, re: rd_stb, addr: addr, wdata: wdata};

   // Event vector: [4:0] link, [5] c0 amp, [6] c0 cal, [7] c1 amp, [8] c1 cal,
   // [9] pll lock, [10] pll lost, [11] dll lock, [12] dll lost
   logic [12:0] en_r;
   logic [12:0] route_r;
   logic [12:0] latch_r;
   logic [1:0]  page_r;
   logic [7:0]  skip_r;
   logic [7:0]  rot_r;
   logic [7:0]  mute_r;
   logic [7:0]  caldiv_r;
   logic [7:0]  caltune_r;
   logic [7:0]  window_r;
   logic        oneshot_r;
   logic        done_r;
   logic [7:0]  calctl_r [2];
   logic [9:0]  fsc_r [2];
   logic [2:0]  calstat_r [2];
   logic [7:0]  calcnt_r [2];
   dac_ctrl_pkg::cal_state_t cal_st_r [2];

   wire wr = ce && req.we;
   wire [7:0] wd = req.wdata;
   function automatic logic hit(input logic [11:0] a);
      hit = wr && (req.addr == a);
   endfunction : hit

   wire [12:0] wr_en_v = {wd[5], wd[4], wd[1], wd[0], wd[3], wd[0], wd[3], wd[0], wd[4:0]};
   wire [12:0] grp_link = 13'h001f;
   wire [12:0] grp_c0   = 13'h0060;
   wire [12:0] grp_c1   = 13'h0180;
   wire [12:0] grp_clk  = 13'h1e00;
   wire [12:0] clk_map  = {wd[5], wd[4], wd[1], wd[0], 9'h000};
   wire [12:0] c1_map   = {4'h0, wd[3], wd[0], 7'h00};
   wire [12:0] c0_map   = {6'h00, wd[3], wd[0], 5'h00};
   wire [12:0] ln_map   = {8'h00, wd[4:0]};

   // Status clear mask from the four status registers and the summary bit
   wire [12:0] clr_v = (hit(`A_ST_LINK) ? ln_map : 13'h0000)
                     | (hit(`A_ST_DAC0) ? c0_map : 13'h0000)
                     | (hit(`A_ST_DAC1) ? c1_map : 13'h0000)
                     | (hit(`A_ST_CLK)  ? clk_map : 13'h0000)
                     | ((hit(`A_SUMMARY) && wd[0]) ? 13'h1fff : 13'h0000);
   wire [12:0] dummy_unused = wr_en_v & (grp_link | grp_c0 | grp_c1 | grp_clk);

   // Sync edge pin: three stages, change taken when stages two and three agree
   logic [2:0] sp_r;
   logic [2:0] tga_r;
   logic [2:0] tgb_r;
   logic       sync_lvl_r;
   logic       gate0_r;
   logic       gate1_r;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sp_r <= '0;
         tga_r <= '1;
         tgb_r <= '1;
         sync_lvl_r <= 1'b0;
         gate0_r <= 1'b1;
         gate1_r <= 1'b1;
      end else if (ce) begin
         sp_r  <= {sp_r[1:0], sync_edge_pin};
         tga_r <= {tga_r[1:0], transmit_gate_pin_0};
         tgb_r <= {tgb_r[1:0], transmit_gate_pin_1};
         if (sp_r[1] == sp_r[2]) sync_lvl_r <= sp_r[2];
         if (tga_r[1] == tga_r[2]) gate0_r <= tga_r[2];
         if (tgb_r[1] == tgb_r[2]) gate1_r <= tgb_r[2];
      end
   end
   logic sync_prev_r;
   wire  sync_rise = sync_lvl_r && !sync_prev_r;

   // Edge timing: period counter measures spacing between sync edges
   logic [7:0] since_r, skipcnt_r;
   logic       seen_r, jitter_r;
   wire [7:0] dev = (since_r > 8'(SYNC_PERIOD)) ? since_r - 8'(SYNC_PERIOD)
                                               : 8'(SYNC_PERIOD) - since_r;
   wire jitter_evt = sync_rise && seen_r && !oneshot_r && (dev > window_r);
   wire skipping   = skipcnt_r != 8'h00;
   wire do_rotate  = sync_rise && oneshot_r && !skipping;

   wire [12:0] live_v = {event_live[12:5], event_live[4] | jitter_r, event_live[3:0]};
   wire [12:0] latch_nxt = (latch_r & ~clr_v) | (live_v & en_r);
   wire [12:0] status_v  = (latch_r & en_r) | (live_v & ~en_r);
   wire        summary   = |status_v;
   wire        pin_a_on  = |(latch_r & en_r & ~route_r);
   wire        pin_b_on  = |(latch_r & en_r & route_r);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_r <= '0;
         route_r <= '0;
         latch_r <= '0;
         page_r <= `RST_PAGE;
         skip_r <= '0;
         window_r <= '0;
         oneshot_r <= 1'b0;
         done_r <= 1'b1;
         rot_r <= `RST_ROT;
         mute_r <= '0;
         caldiv_r <= `RST_CALDIV;
         caltune_r <= `RST_CALTUNE;
         sync_prev_r <= 1'b0;
         since_r <= '0;
         skipcnt_r <= '0;
         seen_r <= 1'b0;
         jitter_r <= 1'b0;
      end else if (ce) begin
         latch_r <= latch_nxt;
         sync_prev_r <= sync_lvl_r;
         jitter_r <= jitter_evt;
         if (sync_rise) since_r <= 8'h01;
         else if (since_r != 8'hff) since_r <= since_r + 8'h01;
         if (sync_rise) seen_r <= 1'b1;
         if (sync_rise && skipping) skipcnt_r <= skipcnt_r - 8'h01;
         if (do_rotate) begin
            oneshot_r <= 1'b0;
            done_r    <= 1'b1;
         end
         if (hit(`A_PAGE)) page_r <= wd[7:6];
         if (hit(`A_EN_LINK)) en_r[4:0] <= wd[4:0];
         if (hit(`A_EN_DAC0)) en_r[6:5] <= {wd[3], wd[0]};
         if (hit(`A_EN_DAC1)) en_r[8:7] <= {wd[3], wd[0]};
         if (hit(`A_EN_CLK))  en_r[12:9] <= {wd[5], wd[4], wd[1], wd[0]};
         if (hit(`A_RT_LINK)) route_r[4:0] <= wd[4:0];
         if (hit(`A_RT_DAC0)) route_r[6:5] <= {wd[3], wd[0]};
         if (hit(`A_RT_DAC1)) route_r[8:7] <= {wd[3], wd[0]};
         if (hit(`A_RT_CLK))  route_r[12:9] <= {wd[5], wd[4], wd[1], wd[0]};
         if (hit(`A_SKIP)) begin
            skip_r <= wd;
            skipcnt_r <= wd;
         end
         if (hit(`A_WINDOW)) window_r <= wd & `M_WINDOW;
         if (hit(`A_MODE) && wd[`B_ONESHOT]) begin
            oneshot_r <= 1'b1;
            done_r    <= 1'b0;
            skipcnt_r <= skip_r;
         end
         if (hit(`A_ROT)) rot_r <= wd & `M_ROT;
         if (hit(`A_MUTE)) mute_r <= wd;
         if (hit(`A_CALDIV)) caldiv_r <= wd;
         if (hit(`A_CALTUNE)) caltune_r <= wd;
      end
   end

   // Per-converter banks for calibration and full-scale code
   genvar g;
   for (g = 0; g < 2; g++) begin : g_bank
      wire sel = page_r[g];
      wire busy = cal_st_r[g] == dac_ctrl_pkg::CAL_RUN;
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            calctl_r[g] <= `RST_CALCTL;
            fsc_r[g] <= FSC_RST;
            calstat_r[g] <= '0;
            calcnt_r[g] <= '0;
            cal_st_r[g] <= dac_ctrl_pkg::CAL_IDLE;
         end else if (ce) begin
            if (sel && hit(`A_CALCTL)) calctl_r[g] <= wd;
            if (sel && hit(`A_FSC_LO)) fsc_r[g][1:0] <= wd[1:0];
            if (sel && hit(`A_FSC_HI)) fsc_r[g][9:2] <= wd;
            case (cal_st_r[g])
               dac_ctrl_pkg::CAL_IDLE: begin
                  if (sel && hit(`A_CALCTL) && wd[`B_START]) begin
                     cal_st_r[g]  <= dac_ctrl_pkg::CAL_RUN;
                     calstat_r[g] <= 3'b100;
                     calcnt_r[g]  <= `CAL_LEN;
                  end
               end
               dac_ctrl_pkg::CAL_RUN: begin
                  if (calcnt_r[g] == 8'h00) begin
                     cal_st_r[g]  <= dac_ctrl_pkg::CAL_IDLE;
                     calstat_r[g] <= {1'b0, calib_fail_in[g], 1'b1};
                  end else begin
                     calcnt_r[g] <= calcnt_r[g] - 8'h01;
                  end
               end
               default: cal_st_r[g] <= dac_ctrl_pkg::CAL_IDLE;
            endcase
         end
      end
      wire unused_busy = busy;
   end

   // Complete flags gathered here are unused; calibration done events come from event_live
   wire [1:0] cal_done_live = {calstat_r[1][0], calstat_r[0][0]};
   wire       bank = !page_r[0] && page_r[1];
   wire [7:0] rd_mux =
        (req.addr == `A_PAGE)    ? {page_r, 6'h00} :
        (req.addr == `A_EN_LINK) ? {3'h0, en_r[4:0]} :
        (req.addr == `A_EN_DAC0) ? {4'h0, en_r[6], 2'h0, en_r[5]} :
        (req.addr == `A_EN_DAC1) ? {4'h0, en_r[8], 2'h0, en_r[7]} :
        (req.addr == `A_EN_CLK)  ? {2'h0, en_r[12:11], 2'h0, en_r[10:9]} :
        (req.addr == `A_ST_LINK) ? {3'h0, status_v[4:0]} :
        (req.addr == `A_ST_DAC0) ? {4'h0, status_v[6], 2'h0, status_v[5]} :
        (req.addr == `A_ST_DAC1) ? {4'h0, status_v[8], 2'h0, status_v[7]} :
        (req.addr == `A_ST_CLK)  ? {2'h0, status_v[12:11], 2'h0, status_v[10:9]} :
        (req.addr == `A_RT_LINK) ? {3'h0, route_r[4:0]} :
        (req.addr == `A_RT_DAC0) ? {4'h0, route_r[6], 2'h0, route_r[5]} :
        (req.addr == `A_RT_DAC1) ? {4'h0, route_r[8], 2'h0, route_r[7]} :
        (req.addr == `A_RT_CLK)  ? {2'h0, route_r[12:11], 2'h0, route_r[10:9]} :
        (req.addr == `A_SUMMARY) ? {7'h00, summary} :
        (req.addr == `A_SKIP)    ? skip_r :
        (req.addr == `A_WINDOW)  ? window_r :
        (req.addr == `A_MODE)    ? {3'h0, done_r, 2'h0, oneshot_r, 1'b0} :
        (req.addr == `A_ROT)     ? rot_r :
        (req.addr == `A_MUTE)    ? mute_r :
        (req.addr == `A_CALDIV)  ? caldiv_r :
        (req.addr == `A_CALCTL)  ? calctl_r[bank] :
        (req.addr == `A_CALSTAT) ? {5'h00, calstat_r[bank]} :
        (req.addr == `A_FSC_LO)  ? {6'h00, fsc_r[bank][1:0]} :
        (req.addr == `A_FSC_HI)  ? fsc_r[bank][9:2] :
        (req.addr == `A_CALTUNE) ? caltune_r : 8'h00;

   logic dig_prev_r;
   wire  dig_fall = dig_prev_r && !digital_reset;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata <= '0;
         event_pin_a_n <= 1'b1;
         event_pin_b_n <= 1'b1;
         conv_mute <= '0;
         serdes_realign <= 1'b0;
         soft_gain_ramp <= 1'b0;
         oscillator_reset <= 1'b0;
         dig_prev_r <= 1'b0;
         full_scale_code_0 <= FSC_RST;
         full_scale_code_1 <= FSC_RST;
      end else if (ce) begin
         rdata <= req.re ? rd_mux : 8'h00;
         event_pin_a_n <= !pin_a_on;
         event_pin_b_n <= !pin_b_on;
         conv_mute <= {mute_r[`B_MUTE0 + 1] && !gate1_r, mute_r[`B_MUTE0] && !gate0_r};
         serdes_realign <= do_rotate && rot_r[`B_ROT_SERDES];
         soft_gain_ramp <= do_rotate && rot_r[`B_ROT_SOFT];
         oscillator_reset <= rot_r[`B_NCO_RST] && (do_rotate || dig_fall);
         dig_prev_r <= digital_reset;
         full_scale_code_0 <= fsc_r[0];
         full_scale_code_1 <= fsc_r[1];
      end
   end
   wire [1:0] unused_cd = cal_done_live;
endmodule : dac_ctrl

/* File: core/dac_ctrl_defines.svh */
/*
 * Register offsets, field positions and reset values of the DAC control bank.
 * Assumes an 8-bit register port with byte-wide offsets as printed.
 */
`ifndef DAC_CTRL_DEFINES_SVH
`define DAC_CTRL_DEFINES_SVH

`define A_PAGE          12'h008
`define A_EN_LINK       12'h020
`define A_EN_DAC0       12'h021
`define A_EN_DAC1       12'h022
`define A_EN_CLK        12'h023
`define A_ST_LINK       12'h024
`define A_ST_DAC0       12'h025
`define A_ST_DAC1       12'h026
`define A_ST_CLK        12'h027
`define A_RT_LINK       12'h028
`define A_RT_DAC0       12'h029
`define A_RT_DAC1       12'h02a
`define A_RT_CLK        12'h02b
`define A_SUMMARY       12'h02c
`define A_SKIP          12'h036
`define A_WINDOW        12'h039
`define A_MODE          12'h03a
`define A_ROT           12'h03b
`define A_MUTE          12'h03f
`define A_CALDIV        12'h050
`define A_CALCTL        12'h051
`define A_CALSTAT       12'h052
`define A_FSC_LO        12'h059
`define A_FSC_HI        12'h05a
`define A_CALTUNE       12'h061

`define M_LINK          8'h1f
`define M_DAC           8'h09
`define M_CLK           8'h33
`define M_WINDOW        8'h7f
`define M_ROT           8'hf3
`define M_MUTE          8'h30

`define RST_PAGE        2'h3
`define RST_ROT         8'hb0
`define RST_CALDIV      8'h28
`define RST_CALCTL      8'h82
`define RST_FSC_LO      8'h28
`define RST_FSC_HI      8'h28
`define RST_CALTUNE     8'h60

`define B_DONE          4
`define B_ONESHOT       1
`define B_NCO_RST       4
`define B_ROT_SERDES    0
`define B_ROT_SOFT      1
`define B_MUTE0         4
`define B_START         0
`define CAL_LEN         8'h40

`endif

/* File: core/dac_ctrl_pkg.sv */
/*
 * Types shared by the DAC control bank.
 * Assumes the defines header is included by users of the offsets.
 */
package dac_ctrl_pkg;
   typedef struct packed {
      logic       we;
      logic       re;
      logic [11:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} cal_state_t;
endpackage : dac_ctrl_pkg

/* File: dv/dac_ctrl_properties.sv */
/* Port assertions for the DAC control bank.
   Assumes one clock and the register offsets of the defines header. */
`include "dac_ctrl_defines.svh"
module dac_ctrl_properties (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [11:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr_stb,
   input wire logic        rd_stb,
   input wire logic [7:0]  rdata,
   input wire logic        transmit_gate_pin_0,
   input wire logic        transmit_gate_pin_1,
   input wire logic        event_pin_a_n,
   input wire logic        event_pin_b_n,
   input wire logic [1:0]  conv_mute,
   input wire logic        serdes_realign,
   input wire logic        soft_gain_ramp,
   input wire logic        oscillator_reset,
   input wire logic [9:0]  full_scale_code_0,
   input wire logic [9:0]  full_scale_code_1
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [1:0] page_r;
   // Shadow of the converter bank select
   always_ff @(posedge clk_sys) begin
      if (rst) page_r <= 2'h3;
      else if (ce && wr_stb && addr == `A_PAGE) page_r <= wdata[7:6];
   end
   chk_fsc_high_0 :
   assert property (ce && wr_stb && addr == `A_FSC_HI && page_r[0]
      |-> ##2 full_scale_code_0[9:2] == $past(wdata, 2)) else $error("full_scale_code_low high bits wrong");
   chk_fsc_low_1 :
   assert property (ce && wr_stb && addr == `A_FSC_LO && page_r[1]
      |-> ##2 full_scale_code_1[1:0] == $past(wdata[1:0], 2)) else $error("full_scale_code_high low bits wrong");
   chk_fsc_held :
   assert property (!$past(ce && wr_stb, 2) |-> $stable(full_scale_code_0))
      else $error("full_scale_code_low moved without a write");
   chk_rdata_quiet :
   assert property ($past(ce) && !$past(rd_stb) |-> rdata == 8'h00)
      else $error("rdata not zero outside read");
   chk_mute_off_0 :
   assert property ((ce && transmit_gate_pin_0)[*6] |-> !conv_mute[0])
      else $error("conv0 muted with gate high");
   chk_mute_off_1 :
   assert property ((ce && transmit_gate_pin_1)[*6] |-> !conv_mute[1])
      else $error("conv1 muted with gate high");
   chk_realign_pulse :
   assert property (serdes_realign |=> !serdes_realign) else $error("realign not a pulse");
   chk_ramp_pulse :
   assert property (soft_gain_ramp |=> !soft_gain_ramp) else $error("ramp not a pulse");
   chk_osc_pulse :
   assert property (oscillator_reset |=> !oscillator_reset) else $error("osc reset not a pulse");
   chk_reset_idle :
   assert property (disable iff (1'b0) rst && ce |=> event_pin_a_n && event_pin_b_n
      && conv_mute == 2'b00 && full_scale_code_1 == 10'h0a0) else $error("reset state wrong");
endmodule : dac_ctrl_properties
bind dac_ctrl dac_ctrl_properties u_props (.*);

/* File: dv/sync_source.sv */
/* Model of the off-chip sync edge source and transmit gate drivers.
   Assumes the bench calls its tasks or sets gap_ns; the sync line rests low. */
module sync_source (
   output logic sync_edge_pin,
   output logic transmit_gate_pin_0,
   output logic transmit_gate_pin_1
);
   timeunit 1ns;
   timeprecision 100ps;
   int gap_ns = 0;
   initial begin
      sync_edge_pin = 1'b0;
      {transmit_gate_pin_1, transmit_gate_pin_0} = 2'b11;
   end
   // Free-running edges while gap_ns is non-zero
   always begin
      wait (gap_ns > 0);
      #(gap_ns - 40) sync_edge_pin = 1'b1;
      #40 sync_edge_pin = 1'b0;
   end
   task automatic edges(input int n, input int g);
      repeat (n) begin
         #(g - 33) sync_edge_pin = 1'b1;
         #40 sync_edge_pin = 1'b0;
      end
   endtask : edges
   task automatic gate(input logic [1:0] v);
      #7 {transmit_gate_pin_1, transmit_gate_pin_0} = v;
   endtask : gate
endmodule : sync_source

/* File: dv/dac_ctrl_tb.sv */
/* Self-checking bench for the DAC control bank.
   Assumes the sync source model and the bound port checker. */
`include "dac_ctrl_defines.svh"
module dac_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PERIOD = 16;
   localparam int EV_BIT [13] = '{0, 1, 2, 3, 4, 0, 3, 0, 3, 0, 1, 4, 5};
   localparam logic [27:0] ROWS [8] = '{{`A_RT_LINK, 8'hff, `M_LINK},
      {`A_RT_DAC0, 8'hff, `M_DAC}, {`A_RT_DAC1, 8'hff, `M_DAC}, {`A_RT_CLK, 8'hff, `M_CLK},
      {`A_SKIP, 8'ha5, 8'ha5}, {`A_WINDOW, 8'hff, `M_WINDOW}, {`A_MUTE, 8'hff, 8'hff},
      {12'h0ff, 8'hff, 8'h00}};
   logic clk_sys, rst, ce, digital_reset, event_pin_a_n, event_pin_b_n;
   logic serdes_realign, soft_gain_ramp, oscillator_reset;
   logic sync_edge_pin, transmit_gate_pin_0, transmit_gate_pin_1;
   logic [1:0] calib_fail_in, conv_mute;
   logic [7:0] rdata, m;
   logic [11:0] ra;
   logic [12:0] event_live;
   logic [9:0] full_scale_code_0, full_scale_code_1;
   logic [2:0] seen = '0;
   dac_ctrl_pkg::reg_req_t req;
   int n_errors = 0;
   int checked = 0;
   dac_ctrl #(.SYNC_PERIOD(PERIOD)) u_dut (.addr(req.addr), .wdata(req.wdata),
      .wr_stb(req.we), .rd_stb(req.re), .*);
   sync_source u_src (.*);
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) seen <= seen | {oscillator_reset, soft_gain_ramp, serdes_realign};
   task automatic end_sim;
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      req <= '0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rdv(input logic [11:0] a, output logic [7:0] d);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      req <= '0;
      #1 d = rdata;
      @(posedge clk_sys);
   endtask : rdv
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [7:0] d;
      rdv(a, d);
      chk(d, e);
   endtask : rd
   task automatic poll;
      logic [7:0] s;
      s = 8'h04;
      for (int k = 0; k < 100 && s[2]; k++) rdv(`A_CALSTAT, s);
      if (s[2]) chk(s, 8'h00);
   endtask : poll
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end
   initial begin
      req = '0;
      {rst, ce, digital_reset, event_live, calib_fail_in} = {2'b11, 14'h0, 2'b10};
      cyc(3);
      rst <= 1'b0;
      cyc(1);
      #1 chk(full_scale_code_0, 10'h0a0);
      chk({event_pin_a_n, event_pin_b_n, conv_mute}, 4'hc);
      rd(`A_MODE, 8'h10);
      rd(`A_ROT, `RST_ROT & `M_ROT);
      rd(`A_SUMMARY, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(ROWS[i][27:16], ROWS[i][15:8]);
         rd(ROWS[i][27:16], ROWS[i][7:0]);
      end
      ce <= 1'b0;
      wr(`A_SKIP, 8'h33);
      ce <= 1'b1;
      rd(`A_SKIP, 8'ha5);
      for (int i = 0; i < 13; i++) begin
         ra = i < 5 ? `A_RT_LINK : i < 7 ? `A_RT_DAC0 : i < 9 ? `A_RT_DAC1 : `A_RT_CLK;
         m = 8'h01 << EV_BIT[i];
         wr(ra, i[0] ? m : 8'h00);
         wr(ra - 12'h008, m);
         event_live[i] <= 1'b1;
         @(posedge clk_sys);
         event_live[i] <= 1'b0;
         cyc(1);
         #1 chk({event_pin_a_n, event_pin_b_n}, i[0] ? 2'b10 : 2'b01);
         wr(ra - 12'h004, 8'h00);
         rd(ra - 12'h004, m);
         rd(`A_SUMMARY, 8'h01);
         if (i[0]) wr(`A_SUMMARY, 8'h01);
         else wr(ra - 12'h004, m);
         rd(ra - 12'h004, 8'h00);
         #1 chk({event_pin_a_n, event_pin_b_n}, 2'b11);
         wr(ra - 12'h008, 8'h00);
      end
      event_live[10] <= 1'b1;
      cyc(2);
      rd(`A_ST_CLK, 8'h02);
      chk({event_pin_a_n, event_pin_b_n}, 2'b11);
      event_live[10] <= 1'b0;
      wr(`A_MUTE, 8'h10);
      u_src.gate(2'b00);
      cyc(8);
      #1 chk(conv_mute, 2'b01);
      u_src.gate(2'b11);
      cyc(8);
      #1 chk(conv_mute, 2'b00);
      wr(`A_PAGE, 8'h40);
      wr(`A_FSC_HI, 8'h55);
      wr(`A_FSC_LO, 8'h03);
      #1 chk(full_scale_code_0, 10'h157);
      chk(full_scale_code_1, 10'h0a0);
      wr(`A_PAGE, 8'hc0);
      wr(`A_FSC_HI, 8'h12);
      #1 chk(full_scale_code_0, 10'h04b);
      chk(full_scale_code_1, 10'h048);
      wr(`A_PAGE, 8'h40);
      wr(`A_CALCTL, `RST_CALCTL | 8'h01);
      rd(`A_CALSTAT, 8'h04);
      poll();
      rd(`A_CALSTAT, 8'h01);
      wr(`A_PAGE, 8'h80);
      rd(`A_CALSTAT, 8'h00);
      wr(`A_CALCTL, `RST_CALCTL | 8'h01);
      poll();
      rd(`A_CALSTAT, 8'h03);
      wr(`A_ROT, 8'hf3);
      wr(`A_SKIP, 8'h02);
      wr(`A_MODE, 8'h02);
      rd(`A_MODE, 8'h02);
      seen = '0;
      u_src.edges(2, PERIOD * 20);
      cyc(8);
      rd(`A_MODE, 8'h02);
      u_src.edges(1, PERIOD * 20);
      cyc(8);
      rd(`A_MODE, 8'h10);
      chk(seen, 3'b111);
      wr(`A_ROT, 8'he0);
      wr(`A_SKIP, 8'h00);
      wr(`A_MODE, 8'h02);
      seen = '0;
      u_src.edges(1, PERIOD * 20);
      cyc(8);
      rd(`A_MODE, 8'h10);
      chk(seen, 3'b000);
      wr(`A_ROT, 8'hf0);
      seen = '0;
      digital_reset <= 1'b1;
      cyc(2);
      digital_reset <= 1'b0;
      cyc(4);
      chk(seen, 3'b100);
      wr(`A_WINDOW, 8'h02);
      u_src.gap_ns = PERIOD * 20;
      cyc(PERIOD * 3);
      wr(`A_SUMMARY, 8'h01);
      wr(`A_EN_LINK, 8'h10);
      cyc(PERIOD * 4);
      rd(`A_ST_LINK, 8'h00);
      u_src.gap_ns = (PERIOD + 5) * 20;
      cyc(PERIOD * 5);
      rd(`A_ST_LINK, 8'h10);
      u_src.gap_ns = 0;
      end_sim();
   end
endmodule : dac_ctrl_tb
